// ==== verilog/fcr_defines.svh ====
`ifndef FCR_DEFINES_SVH
`define FCR_DEFINES_SVH
`define FCR_ADDR_MODE 8'h28
`define FCR_ADDR_WM_LO 8'h29
`define FCR_ADDR_WM_HI 8'h2A
`define FCR_ADDR_ROUTE 8'h2B
`define FCR_RST_MODE 8'h01
`define FCR_RST_WM_LO 8'h00
`define FCR_RST_WM_HI 8'h00
`define FCR_RST_ROUTE 8'h10
`define FCR_MODE_MASK 8'h03
`define FCR_WM_HI_MASK 8'h0F
`define FCR_BIT_BYPASS 0
`define FCR_BIT_STOP 1
`define FCR_BIT_GAIN 0
`define FCR_BIT_FULL 1
`define FCR_BIT_WMARK 2
`define FCR_BIT_SAMPLE 3
`define FCR_BIT_RESET 4
`define FCR_BIT_LOCK 5
`define FCR_BIT_FRAME_SYNC_INPUT 6
`define FCR_BIT_SELFTEST 7
`endif

// ==== verilog/fcr_pkg.sv ====
package fcr_pkg;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] wm_lo;
    logic [7:0] wm_hi;
    logic [7:0] route;
    logic [7:0] rdata;
    logic rvalid;
    logic fs_s1;
    logic fs_s2;
    logic fs_prev;
    logic above;
    logic wm_hit;
    logic irq;
  } fcr_state_t;
endpackage

// ==== verilog/fcr_top.sv ====
`timescale 1ns/1ns
`include "fcr_defines.svh"
module fcr_top
  import fcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic watermark_irq_enable,
  input wire logic count_in_records,
  input wire logic [11:0] level_bytes,
  input wire logic [11:0] level_records,
  input wire logic buffer_full,
  input wire logic selftest_done,
  input wire logic frame_sync_input,
  input wire logic clock_locked,
  input wire logic reset_done,
  input wire logic new_sample,
  input wire logic gain_ready,
  output logic stop_on_full,
  output logic buffer_bypass,
  output logic [11:0] buffer_watermark,
  output logic watermark_hit,
  output logic first_irq_pin
);

  fcr_state_t st_r;
  fcr_state_t st_nxt;

  logic [11:0] wm;
  logic [11:0] level;
  logic above_now;
  logic fs_event;
  logic [7:0] events;
  logic [7:0] routed;

  assign wm = {st_r.wm_hi[3:0], st_r.wm_lo};
  assign level = count_in_records ? level_records : level_bytes;
  assign above_now = (level >= wm);
  assign fs_event = st_r.fs_s2 & ~st_r.fs_prev;

  always_comb begin
    events = 8'h00;
    events[`FCR_BIT_SELFTEST] = selftest_done;
    events[`FCR_BIT_FRAME_SYNC_INPUT] = fs_event;
    events[`FCR_BIT_LOCK] = clock_locked;
    events[`FCR_BIT_RESET] = reset_done;
    events[`FCR_BIT_SAMPLE] = new_sample;
    events[`FCR_BIT_WMARK] = st_r.wm_hit;
    events[`FCR_BIT_FULL] = buffer_full;
    events[`FCR_BIT_GAIN] = gain_ready;
  end

  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_route
      // Each source gated by its own routing bit
      assign routed[b] = events[b] & st_r.route[b];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    // Pin synchroniser and edge detect on the synchronised copy
    st_nxt.fs_s1 = frame_sync_input;
    st_nxt.fs_s2 = st_r.fs_s1;
    st_nxt.fs_prev = st_r.fs_s2;
    // Register writes; reserved bits stay zero
    if (reg_wr) begin
      unique case (reg_addr)
        `FCR_ADDR_MODE: begin
          st_nxt.mode = reg_wdata & `FCR_MODE_MASK;
        end
        `FCR_ADDR_WM_LO: begin
          st_nxt.wm_lo = reg_wdata;
        end
        `FCR_ADDR_WM_HI: begin
          st_nxt.wm_hi = reg_wdata & `FCR_WM_HI_MASK;
        end
        `FCR_ADDR_ROUTE: begin
          st_nxt.route = reg_wdata;
        end
        default: begin
          st_nxt.route = st_r.route;
        end
      endcase
    end
    // Reads answer one cycle later; unmapped reads return zero
    st_nxt.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `FCR_ADDR_MODE: st_nxt.rdata = st_r.mode;
        `FCR_ADDR_WM_LO: st_nxt.rdata = st_r.wm_lo;
        `FCR_ADDR_WM_HI: st_nxt.rdata = st_r.wm_hi;
        `FCR_ADDR_ROUTE: st_nxt.rdata = st_r.route;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    // One pulse per upward crossing while enabled
    st_nxt.above = above_now;
    st_nxt.wm_hit = watermark_irq_enable & above_now & ~st_r.above;
    // Pin is the OR of all routed sources
    st_nxt.irq = |routed;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.mode <= `FCR_RST_MODE;
      st_r.wm_lo <= `FCR_RST_WM_LO;
      st_r.wm_hi <= `FCR_RST_WM_HI;
      st_r.route <= `FCR_RST_ROUTE;
      st_r.rdata <= 8'h00;
      st_r.rvalid <= 1'b0;
      st_r.fs_s1 <= 1'b0;
      st_r.fs_s2 <= 1'b0;
      st_r.fs_prev <= 1'b0;
      st_r.above <= 1'b1;
      st_r.wm_hit <= 1'b0;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign stop_on_full = st_r.mode[`FCR_BIT_STOP];
  assign buffer_bypass = st_r.mode[`FCR_BIT_BYPASS];
  assign buffer_watermark = wm;
  assign watermark_hit = st_r.wm_hit;
  assign first_irq_pin = st_r.irq;

endmodule

// ==== sim/fcr_asserts.sv ====
`timescale 1ns/1ns
module fcr_checks(input logic clk, reset, reg_wr, reg_rd, reg_rvalid, stop_on_full,
  buffer_bypass, watermark_hit, watermark_irq_enable, input logic [7:0] reg_addr, reg_wdata,
  input logic [11:0] buffer_watermark);
  wire w8=reg_wr&&reg_addr==8'h28, w9=reg_wr&&reg_addr==8'h29, wa=reg_wr&&reg_addr==8'h2A;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  rd_answer_a: assert property(reg_rvalid==$past(reg_rd)) else $error("rv");
  mode_stop_a: assert property(w8|=>stop_on_full==$past(reg_wdata[1])) else $error("st");
  mode_byp_a: assert property(w8|=>buffer_bypass==$past(reg_wdata[0])) else $error("by");
  wm_low_a: assert property(w9|=>buffer_watermark[7:0]==$past(reg_wdata))
    else $error("lo");
  wm_high_a: assert property(wa|=>buffer_watermark[11:8]==$past(reg_wdata[3:0]))
    else $error("hi");
  wm_hold_a: assert property(!w9&&!wa|=>$stable(buffer_watermark)) else $error("wm");
  hit_once_a: assert property(watermark_hit|=>!watermark_hit) else $error("ht");
  hit_gate_a: assert property(watermark_hit|->$past(watermark_irq_enable))
    else $error("en");
  cover property(watermark_hit);
  cover property(w8);
  cover property(reg_rvalid);
endmodule
bind fcr_top fcr_checks chk(.*);

// ==== sim/fcr_host.sv ====
`timescale 1ns/1ns
module fcr_host(input logic clk, input logic [7:0] reg_rdata, output logic [7:0] reg_addr = 0,
  reg_wdata = 0, output logic reg_wr = 0, reg_rd = 0, watermark_irq_enable = 0);
  task wr(input logic [7:0] a, d);
    @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk) reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk) reg_rd = 0;
    d = reg_rdata;
  endtask
endmodule

// ==== sim/test_fcr_top.sv ====
`timescale 1ns/1ns
`define CK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected %0t value mismatch", $time); end end
module test_fcr_top;
  logic clk = 0, reset = 1, count_in_records = 1, reg_wr, reg_rd, reg_rvalid, watermark_hit;
  logic watermark_irq_enable, stop_on_full, buffer_bypass, first_irq_pin;
  logic [7:0] ev = 0, reg_addr, reg_wdata, reg_rdata, d, e;
  logic [11:0] level_bytes = 0, level_records = 0, buffer_watermark, w;
  int bad_count = 0, comparisons = 0, cyc = 0, i, n;
  wire selftest_done = ev[7], frame_sync_input = ev[6], clock_locked = ev[5];
  wire reset_done = ev[4], new_sample = ev[3], buffer_full = ev[1], gain_ready = ev[0];
  fcr_top uut(.*);
  fcr_host host(.*);
  always #50 clk = ~clk;
  always @(posedge clk) if (++cyc == 2000) begin bad_count++; complete_run; end
  task complete_run;
    $display("%0d %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h65286E65));
    repeat (10) @(negedge clk);
    reset = 0;
    `CK({stop_on_full, buffer_bypass, buffer_watermark}, 14'h1000)
    for (i = 0; i < 25; i++) begin
      if (i > 4) host.wr(8'h28 + 8'(i % 5), d);
      host.rd(8'h28 + 8'(i % 5), e);
      `CK({reg_rvalid, e}, {1'b1, 8'((i<5 ? 40'h0010000001 : {5{d}} & 40'h00FF0FFF03) >> i%5*8)})
      d = $urandom;
    end
    host.wr(8'h28, 8'h02);
    `CK({stop_on_full, buffer_bypass}, 2'b10)
    $display("t1");
    for (i = 0; i < 8; i++) begin
      host.wr(8'h2B, 8'h01 << i);
      n = 0;
      ev = ~(8'h01 << i) & 8'hFB;
      repeat (6) @(negedge clk) n += 10 * first_irq_pin;
      ev = 8'h01 << i;
      repeat (6) @(negedge clk) {n, ev} = {n + first_irq_pin, 8'h00};
      `CK(n, i != 2)
    end
    $display("t2");
    host.watermark_irq_enable = 0;
    w = $urandom_range(4095, 1);
    host.wr(8'h29, w[7:0]);
    host.wr(8'h2A, {4'h0, w[11:8]});
    host.wr(8'h2B, 8'h04);
    host.watermark_irq_enable = 1;
    level_records = w - 12'h1;
    repeat (2) @(negedge clk);
    level_records = w;
    n = 0;
    repeat (6) @(negedge clk) n += watermark_hit + 10 * first_irq_pin;
    `CK(n, 11)
    `CK(buffer_watermark, w)
    count_in_records = 0;
    level_bytes = w - 12'h1;
    repeat (2) @(negedge clk);
    level_bytes = w;
    n = 0;
    repeat (6) @(negedge clk) n += watermark_hit + 10 * first_irq_pin;
    `CK(n, 11)
    $display("t3");
    complete_run;
  end
endmodule
